// >>> hw/qawd_pkg.sv
package qawd_pkg;

  // register byte offsets
  localparam logic [7:0] QLO_OFS = 8'h00;
  localparam logic [7:0] QHI_OFS = 8'h04;
  localparam logic [7:0] DELAY_OFS = 8'h08;
  localparam logic [7:0] ANSWER_OFS = 8'h0C;
  localparam logic [7:0] CTRL_OFS = 8'h10;
  localparam logic [7:0] STAT_OFS = 8'h14;

  // control register bits
  localparam int CTRL_SOFT_BIT = 0;
  localparam int CTRL_AFTER_BIT = 1;

  // counter values
  localparam logic [2:0] EC_RESET = 3'h6;
  localparam logic [2:0] EC_MAX = 3'h7;
  localparam logic [2:0] EC_ALARM = 3'h4;
  localparam logic [2:0] ABORT_MAX = 3'h7;
  localparam logic [5:0] DELAY_RESET = 6'h3F;
  localparam logic [1:0] BYTE_FIRST = 2'h3;
  localparam logic [1:0] BYTE_LAST = 2'h0;
  localparam logic [3:0] STEP_RESET = 4'h0;
  localparam logic [3:0] CHAIN_RESET = 4'h0;
  localparam logic [3:0] STEP_WRAP = 4'hF;

  // timing: one watchdog tick per TICK_US
  localparam int CLK_MHZ = 100;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
  localparam logic [7:0] WINDOW_TICKS = 8'h10;

  typedef enum logic [1:0] {
    PH_WAIT = 2'b01,
    PH_WINDOW = 2'b10
  } qawd_phase_type;

  // expected answer byte for question q and byte index c
  function automatic logic [7:0] qawd_expect(input logic [3:0] q,
                                             input logic [1:0] c);
    qawd_expect = {q[2] ^ c[0], q[0] ^ c[0], q[3] ^ c[0], q[1] ^ c[0],
                   q[2] ^ q[0] ^ q[3] ^ c[1], q[0] ^ q[3] ^ q[1] ^ c[1],
                   q[2] ^ q[0] ^ q[1] ^ c[1], c[1] ^ q[3] ^ q[0]};
  endfunction

endpackage

// >>> hw/qawd_question_gen.sv
`timescale 1ns/10ps
module qawd_question_gen
  import qawd_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic advance,
  input wire logic [1:0] byteIdx,
  output logic [3:0] question,
  output logic [7:0] expectedByte
);

  logic [3:0] step_reg;
  logic [3:0] chain_reg;
  logic feedback;
  logic stepWrap;

  ////////////////////////////////////////////////////////////////////////
  // step counter and chain

  assign feedback = (chain_reg[3] ^ chain_reg[2]) | (chain_reg == 4'h0);
  assign stepWrap = step_reg == STEP_WRAP;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      step_reg <= STEP_RESET;
      chain_reg <= CHAIN_RESET;
    end
    else if (advance)
    begin
      step_reg <= step_reg + 4'h1;
      if (stepWrap)
        chain_reg <= {chain_reg[2:0], feedback};
    end
  end

  assign question = {chain_reg[2] ^ step_reg[2], chain_reg[0] ^ step_reg[0],
                     chain_reg[3] ^ step_reg[3],
                     chain_reg[1] ^ step_reg[1]};
  assign expectedByte = qawd_expect(question, byteIdx);

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  step_hold_a: assert property (!advance |=> $stable(step_reg) && $stable(chain_reg))
    else $error("step or chain moved without advance");
  step_adv_a: assert property (advance |=> step_reg == $past(step_reg) + 4'h1)
    else $error("step counter did not advance");
  chain_adv_a: assert property (advance && stepWrap |=>
      chain_reg == {$past(chain_reg[2:0]), $past(feedback)})
    else $error("chain did not shift on wrap");
  question_map_a: assert property (question[1] == (chain_reg[3] ^ step_reg[3])
      && question[3] == (chain_reg[2] ^ step_reg[2]))
    else $error("question bit mapping wrong");

endmodule // qawd_question_gen

// >>> hw/qawd_watchdog.sv
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/10ps
// What this block does
// - abort counter rises on each error counter overflow in a run until it holds 7
// - 4-bit question is readable in the question-low register
// - answer byte 0 or delay write starts a cycle: wait then window, or window alone at zero delay
// - window expiry starts a new cycle by itself
// - good timely answer decrements counter; bad, late or zero delay increments
// - only answer byte 0 must land inside the window
// - question repeats until answered right in value and time
// - error counter is 3 bits and resets to 6
// - result and next question readable once byte 0 is in
// - step counter advances only after a good timely answer
// - chain advances when step counter wraps after a good answer
// - delay writes and expiries leave step and chain alone
// - undervoltage reset zeroes step counter and chain
// - chain feedback is bit3 xor bit2, plus escape from all zeros
// - question bits mix chain and step bits in fixed order
// - count above 4 raises alarm; 0 to 4 clears alarm and abort
// - abort counter never decrements; clears below 5 and on reset
// - abort counter rises below 7 on overflow or soft reset with alarm
// - overflow is an error found while the counter holds 7
// - abort sets when abort count is 7 and error or soft reset
// - in after-run an active abort requests shut-down
// - error counter loads 6 after start, reset and overflow
module qawd_watchdog
  import qawd_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES,
  parameter logic [7:0] WINDOW_LEN = WINDOW_TICKS
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic alarmInternal,
  output logic alarmPinOut,
  output logic alarmPinOe,
  output logic afterrunAbort,
  output logic shutdownReq
);

  localparam int TW = $clog2(TICK_LEN + 1);

  logic [TW-1:0] tickCnt_reg;
  logic tick;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [5:0] delay_reg;
  logic afterrun_reg;
  logic [1:0] byteIdx_reg;
  logic respErr_reg;
  logic valueOk_reg;
  logic inTime_reg;
  logic [2:0] ec_reg;
  logic [2:0] ec_next;
  logic [2:0] abortCnt_reg;
  logic abort_reg;
  logic alarm_reg;
  logic alarmOe_reg;
  logic alarmOut_reg;
  logic shutdown_reg;
  qawd_phase_type phase_reg;
  qawd_phase_type phase_next;
  logic [7:0] timer_reg;
  logic [7:0] timer_next;
  logic [3:0] question;
  logic [7:0] expectedByte;

  ////////////////////////////////////////////////////////////////////////
  // tick divider

  assign tick = tickCnt_reg == TW'(TICK_LEN - 1);

  always_ff @(posedge core_clk)
  begin
    if (!rst_n || tick)
      tickCnt_reg <= '0;
    else
      tickCnt_reg <= tickCnt_reg + TW'(1);
  end

  ////////////////////////////////////////////////////////////////////////
  // bus decode

  logic setupPhase;
  logic wrDone;
  logic selQlo;
  logic selQhi;
  logic selDelay;
  logic selAnswer;
  logic selCtrl;
  logic selStat;
  logic mapped;
  logic [31:0] rdataSel;

  assign setupPhase = psel & ~penable;
  assign wrDone = psel & penable & pready_reg & pwrite;
  assign selQlo = paddr == QLO_OFS;
  assign selQhi = paddr == QHI_OFS;
  assign selDelay = paddr == DELAY_OFS;
  assign selAnswer = paddr == ANSWER_OFS;
  assign selCtrl = paddr == CTRL_OFS;
  assign selStat = paddr == STAT_OFS;
  assign mapped = selQlo | selQhi | selDelay | selAnswer | selCtrl | selStat;

  assign rdataSel =
    selQlo ? {28'h0000000, question} :
    selQhi ? {25'h0000000, ec_reg, 2'h0, inTime_reg, valueOk_reg} :
    selDelay ? {26'h0000000, delay_reg} :
    selCtrl ? {30'h00000000, afterrun_reg, 1'h0} :
    selStat ? {19'h00000, phase_reg, shutdown_reg, alarm_reg, abort_reg,
               1'h0, abortCnt_reg, 1'h0, ec_reg} :
    32'h00000000;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
    end
    else
    begin
      pready_reg <= setupPhase;
      pslverr_reg <= setupPhase & ~mapped;
      if (setupPhase)
        prdata_reg <= rdataSel;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // events of a sequencer run

  logic delayWrite;
  logic answerWrite;
  logic softRst;
  logic lastByte;
  logic byteOk;
  logic valueOk;
  logic inWindow;
  logic delayZero;
  logic runGood;
  logic expiry;
  logic runStart;
  logic runError;
  logic overflow;
  logic alarmNow;

  assign delayWrite = wrDone & selDelay;
  assign answerWrite = wrDone & selAnswer;
  assign softRst = wrDone & selCtrl & pwdata[CTRL_SOFT_BIT];
  assign lastByte = answerWrite & (byteIdx_reg == BYTE_LAST);
  assign byteOk = pwdata[7:0] == expectedByte;
  assign valueOk = ~respErr_reg & byteOk;
  assign inWindow = phase_reg == PH_WINDOW;
  assign delayZero = delay_reg == 6'h00;
  assign runGood = lastByte & valueOk & inWindow & ~delayZero;
  assign expiry = tick & inWindow & (timer_reg == 8'h01) &
                  ~lastByte & ~delayWrite;
  assign runStart = lastByte | delayWrite | expiry;
  assign runError = (lastByte & ~runGood) | expiry;
  assign overflow = runError & (ec_reg == EC_MAX) & ~softRst;
  assign alarmNow = ec_reg > EC_ALARM;

  ////////////////////////////////////////////////////////////////////////
  // answer byte tracking

  always_ff @(posedge core_clk)
  begin
    if (!rst_n || softRst || runStart)
    begin
      byteIdx_reg <= BYTE_FIRST;
      respErr_reg <= 1'b0;
    end
    else if (answerWrite)
    begin
      byteIdx_reg <= byteIdx_reg - 2'h1;
      respErr_reg <= respErr_reg | ~byteOk;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      valueOk_reg <= 1'b0;
      inTime_reg <= 1'b0;
    end
    else if (lastByte)
    begin
      valueOk_reg <= valueOk;
      inTime_reg <= inWindow & ~delayZero;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // configuration

  always_ff @(posedge core_clk)
  begin
    if (!rst_n || softRst)
      delay_reg <= DELAY_RESET;
    else if (delayWrite)
      delay_reg <= pwdata[5:0];
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      afterrun_reg <= 1'b0;
    else if (wrDone && selCtrl)
      afterrun_reg <= pwdata[CTRL_AFTER_BIT];
  end

  ////////////////////////////////////////////////////////////////////////
  // monitoring cycle timer

  logic [7:0] delayTicks;

  assign delayTicks = {2'h0, pwdata[5:0]};

  always_comb
  begin
    phase_next = phase_reg;
    timer_next = timer_reg;
    if (softRst)
    begin
      phase_next = PH_WAIT;
      timer_next = {2'h0, DELAY_RESET};
    end
    else if (delayWrite)
    begin
      phase_next = (delayTicks == 8'h00) ? PH_WINDOW : PH_WAIT;
      timer_next = (delayTicks == 8'h00) ? WINDOW_LEN : delayTicks;
    end
    else if (runStart)
    begin
      phase_next = delayZero ? PH_WINDOW : PH_WAIT;
      timer_next = delayZero ? WINDOW_LEN : {2'h0, delay_reg};
    end
    else if (tick)
    begin
      if (timer_reg == 8'h01 && phase_reg == PH_WAIT)
      begin
        phase_next = PH_WINDOW;
        timer_next = WINDOW_LEN;
      end
      else if (timer_reg != 8'h00)
        timer_next = timer_reg - 8'h01;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      phase_reg <= PH_WAIT;
      timer_reg <= {2'h0, DELAY_RESET};
    end
    else
    begin
      phase_reg <= phase_next;
      timer_reg <= timer_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // error counter

  logic [2:0] ecDec;
  logic [2:0] ecInc;

  assign ecDec = (ec_reg == 3'h0) ? 3'h0 : ec_reg - 3'h1;
  assign ecInc = overflow ? EC_RESET : ec_reg + 3'h1;
  assign ec_next = softRst ? EC_RESET :
                   runGood ? ecDec :
                   runError ? ecInc : ec_reg;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      ec_reg <= EC_RESET;
    else
      ec_reg <= ec_next;
  end

  ////////////////////////////////////////////////////////////////////////
  // alarm, abort counter and abort

  logic abortInc;
  logic abortSet;

  assign abortInc = (overflow | (softRst & alarmNow)) &
                    (abortCnt_reg < ABORT_MAX);
  assign abortSet = (abortCnt_reg == ABORT_MAX) & (runError | softRst);

  always_ff @(posedge core_clk)
  begin
    if (!rst_n || !alarmNow)
    begin
      abortCnt_reg <= 3'h0;
      abort_reg <= 1'b0;
    end
    else
    begin
      if (abortInc)
        abortCnt_reg <= abortCnt_reg + 3'h1;
      if (abortSet)
        abort_reg <= 1'b1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      alarm_reg <= 1'b1;
      alarmOe_reg <= 1'b1;
      alarmOut_reg <= 1'b0;
      shutdown_reg <= 1'b0;
    end
    else
    begin
      alarm_reg <= ec_next > EC_ALARM;
      alarmOe_reg <= ec_next > EC_ALARM;
      alarmOut_reg <= 1'b0;
      shutdown_reg <= abort_reg & afterrun_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // question generator

  qawd_question_gen u_qgen (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .advance(runGood),
    .byteIdx(byteIdx_reg),
    .question(question),
    .expectedByte(expectedByte)
  );

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign alarmInternal = alarm_reg;
  assign alarmPinOut = alarmOut_reg;
  assign alarmPinOe = alarmOe_reg;
  assign afterrunAbort = abort_reg;
  assign shutdownReq = shutdown_reg;

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  ec_dec_a: assert property (runGood && !softRst && ec_reg != 3'h0 |=>
      ec_reg == $past(ec_reg) - 3'h1)
    else $error("error counter did not decrement");
  ec_inc_a: assert property (runError && !softRst && ec_reg < EC_MAX |=>
      ec_reg == $past(ec_reg) + 3'h1)
    else $error("error counter did not increment");
  ec_reload_a: assert property (overflow |=> ec_reg == EC_RESET)
    else $error("overflow did not reload six");
  ec_floor_a: assert property (runGood && ec_reg == 3'h0 |=> ec_reg == 3'h0)
    else $error("error counter left zero on good answer");
  alarm_map_a: assert property (alarm_reg == (ec_reg > EC_ALARM)
      && alarmOe_reg == alarm_reg)
    else $error("alarm does not follow error counter");
  abort_clear_a: assert property (!alarmNow |=>
      abortCnt_reg == 3'h0 && !abort_reg)
    else $error("abort state not cleared below five");
  abort_inc_a: assert property (overflow && alarmNow &&
      abortCnt_reg < ABORT_MAX |=> abortCnt_reg == $past(abortCnt_reg) + 3'h1)
    else $error("abort counter did not rise on overflow");
  abort_set_a: assert property (alarmNow && abortCnt_reg == ABORT_MAX &&
      runError |=> abort_reg)
    else $error("abort not set at full count");
  shutdown_a: assert property (abort_reg && afterrun_reg |=> shutdownReq)
    else $error("no shut-down request in after-run");
  restart_a: assert property (expiry && !softRst |=> phase_reg ==
      (delayZero ? PH_WINDOW : PH_WAIT) && timer_reg != 8'h00)
    else $error("cycle did not restart after window");

  good_cov: cover property (runGood);
  overflow_cov: cover property (overflow);
  abort_cov: cover property (abortSet && alarmNow);
  expiry_cov: cover property (expiry);

endmodule // qawd_watchdog

// >>> sim/qawd_mcu_model.sv
`timescale 1ns/10ps
module qawd_mcu_model
  import qawd_pkg::*;
(
  input wire logic core_clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  logic hung;

  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    hung = 1'b0;
  end

  // answer byte c for question q
  function automatic logic [7:0] ansByte(input logic [3:0] q,
                                         input logic [1:0] c);
    logic [3:0] hi;
    logic [3:0] lo;
    hi = {q[2], q[0], q[3], q[1]} ^ {4{c[0]}};
    lo = {q[2] ^ q[0] ^ q[3], q[0] ^ q[3] ^ q[1], q[2] ^ q[0] ^ q[1],
          q[3] ^ q[0]} ^ {4{c[1]}};
    return {hi, lo};
  endfunction

  ////////////////////////////////////////
  // one apb transfer, then an idle cycle
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic err);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    hung = hung | (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
    @(posedge core_clk);
  endtask

  // set delay, send bytes 3..1, wait for window, send byte 0
  task automatic answer(input logic [3:0] q, input logic bad,
                        input logic [5:0] dly);
    logic [31:0] rd;
    logic [7:0] b;
    logic err;
    int i;
    int n;
    xfer(1'b1, DELAY_OFS, {26'h0, dly}, rd, err);
    for (i = 3; i >= 0; i--)
    begin
      b = ansByte(q, 2'(i));
      if (bad && i == 1)
        b = ~b;
      rd = 32'h0;
      n = 0;
      while (i == 0 && n < 40 && rd[12:11] !== PH_WINDOW)
      begin
        xfer(1'b0, STAT_OFS, 32'h0, rd, err);
        n++;
      end
      hung = hung | (n == 40);
      xfer(1'b1, ANSWER_OFS, {24'h0, b}, rd, err);
    end
  endtask
endmodule // qawd_mcu_model

// >>> sim/tb.sv
`timescale 1ns/10ps
module tb
  import qawd_pkg::*;
;
  logic core_clk;
  logic rst_n;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic alarmInternal;
  logic alarmPinOut;
  logic alarmPinOe;
  logic afterrunAbort;
  logic shutdownReq;
  logic alarmPin;
  logic [3:0] step;
  logic [3:0] chain;
  logic [2:0] ecExp;
  logic [2:0] cntExp;
  logic abortExp;
  logic [31:0] rd;
  int nMismatch;
  int comparisons;

  // open-drain alarm line with pull-up
  assign alarmPin = alarmPinOe ? alarmPinOut : 1'b1;

  qawd_watchdog #(.TICK_LEN(4), .WINDOW_LEN(8'h08)) dut (
    .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .alarmInternal(alarmInternal),
    .alarmPinOut(alarmPinOut), .alarmPinOe(alarmPinOe),
    .afterrunAbort(afterrunAbort), .shutdownReq(shutdownReq)
  );

  qawd_mcu_model mcu (
    .core_clk(core_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    comparisons++;
    if (got !== exp)
    begin
      nMismatch++;
      $display("[FAIL] %0t %s: got %h, expected %h", $time, what, got, exp);
    end
  endtask

  task automatic rdReg(input logic [7:0] a);
    logic e;
    mcu.xfer(1'b0, a, 32'h0, rd, e);
  endtask

  task automatic wrReg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic e;
    mcu.xfer(1'b1, a, d, x, e);
  endtask

  function automatic logic [3:0] qPred();
    return {chain[2] ^ step[2], chain[0] ^ step[0], chain[3] ^ step[3],
            chain[1] ^ step[1]};
  endfunction

  // status, alarm pin and question against the model
  task automatic chkAll();
    if (ecExp <= 3'h4)
    begin
      cntExp = 3'h0;
      abortExp = 1'b0;
    end
    rdReg(STAT_OFS);
    chk(rd[10:0], {abortExp, ecExp > 3'h4, abortExp, 1'b0, cntExp, 1'b0,
        ecExp}, "status");
    chk(alarmPin, ecExp <= 3'h4, "alarm pin");
    chk(alarmInternal, ecExp > 3'h4, "alarm internal");
    chk(afterrunAbort, abortExp, "abort output");
    chk(shutdownReq, abortExp, "shutdown output");
    rdReg(QLO_OFS);
    chk(rd, qPred(), "question");
  endtask

  task automatic conclude();
    $display("counts: %0d comparisons, %0d mismatches", comparisons,
             nMismatch);
    if (nMismatch == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  always @(posedge core_clk)
    if (mcu.hung === 1'b1)
    begin
      nMismatch++;
      $display("[FAIL] %0t bus wait ran out", $time);
      conclude();
    end

  ////////////////////////////////////////
  task automatic tReset();
    logic e;
    ecExp = EC_RESET;
    cntExp = 3'h0;
    abortExp = 1'b0;
    step = STEP_RESET;
    chain = CHAIN_RESET;
    chkAll();
    rdReg(DELAY_OFS);
    chk(rd, 32'h3F, "delay reset");
    mcu.xfer(1'b0, 8'h18, 32'h0, rd, e);
    chk(e, 1'b1, "unmapped error");
    $display("test reset done");
  endtask

  task automatic tSoft();
    int i;
    for (i = 1; i <= 8; i++)
    begin
      wrReg(CTRL_OFS, 32'h3);
      cntExp = (i < 8) ? 3'(i) : ABORT_MAX;
      abortExp = (i == 8);
      chkAll();
    end
    $display("test soft reset done");
  endtask

  task automatic tGood();
    int i;
    for (i = 0; i < 18; i++)
    begin
      mcu.answer(qPred(), 1'b0, 6'h01);
      ecExp = (ecExp == 3'h0) ? 3'h0 : ecExp - 3'h1;
      if (step == STEP_WRAP)
        chain = {chain[2:0], (chain[3] ^ chain[2]) | (chain == 4'h0)};
      step = step + 4'h1;
      rdReg(QHI_OFS);
      chk(rd[6:0], {ecExp, 4'h3}, "result");
      chkAll();
    end
    $display("test good answers done");
  endtask

  task automatic tBad();
    int n;
    mcu.answer(qPred(), 1'b1, 6'h01);
    ecExp = ecExp + 3'h1;
    rdReg(QHI_OFS);
    chk(rd[1:0], 2'h2, "wrong value");
    chkAll();
    mcu.answer(qPred(), 1'b0, 6'h00);
    ecExp = ecExp + 3'h1;
    rdReg(QHI_OFS);
    chk(rd[1:0], 2'h1, "zero delay");
    chkAll();
    wrReg(DELAY_OFS, 32'h1);
    ecExp = ecExp + 3'h1;
    n = 0;
    do
    begin
      rdReg(STAT_OFS);
      n++;
    end while (rd[2:0] !== ecExp && n < 40);
    if (rd[2:0] !== ecExp)
    begin
      nMismatch++;
      $display("[FAIL] %0t window expiry wait ran out", $time);
      conclude();
    end
    chkAll();
    wrReg(CTRL_OFS, 32'h3);
    ecExp = EC_RESET;
    chkAll();
    for (n = 1; n <= 4; n++)
    begin
      mcu.answer(qPred(), 1'b1, 6'h01);
      ecExp = (ecExp == EC_MAX) ? EC_RESET : ecExp + 3'h1;
      if (ecExp == EC_RESET)
        cntExp = cntExp + 3'h1;
      chkAll();
    end
    $display("test errors done");
  endtask

  initial
  begin
    rst_n = 1'b0;
    nMismatch = 0;
    comparisons = 0;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    tReset();
    tSoft();
    tGood();
    tBad();
    conclude();
  end
endmodule // tb
